// ---- design/vmsvc_pkg.sv ----
// package for the virtual cpu interface maintenance status and vm control block
// assumes a single core clock domain and system register style access ports
package vmsvc_pkg;
  // register identifiers on the system register access port
  localparam logic [1:0] REG_MAINT_STATUS = 2'h0;  // maintenance status, read only
  localparam logic [1:0] REG_VM_CONTROL   = 2'h1;  // virtual machine control
  // maintenance status bit positions
  localparam int MS_GRP1_DIS  = 7;
  localparam int MS_GRP1_EN   = 6;
  localparam int MS_GRP0_DIS  = 5;
  localparam int MS_GRP0_EN   = 4;
  localparam int MS_NO_PEND   = 3;
  localparam int MS_ABSENT    = 2;
  localparam int MS_FEW_VALID = 1;
  localparam int MS_COMPLETE  = 0;
  localparam logic [7:0] MS_RESET = 8'h00;
  // vm control field positions
  localparam int VC_PMASK_LSB = 24;
  localparam int VC_BP0_LSB   = 21;
  localparam int VC_BP1_LSB   = 18;
  localparam int VC_SPLIT     = 9;
  localparam int VC_CBP       = 4;
  localparam int VC_FIQ       = 3;
  localparam int VC_ACK       = 2;
  localparam int VC_EN1       = 1;
  localparam int VC_EN0       = 0;
  // vm control reset values (fields are unknown architecturally; zero chosen)
  localparam logic [7:0] VC_PMASK_RST = 8'h00;
  localparam logic       VC_BIT_RST   = 1'b0;
  // list entry state encodings
  localparam logic [1:0] LS_INVALID = 2'h0;
  localparam logic [1:0] LS_PENDING = 2'h1;
  localparam logic [1:0] LS_ACTIVE  = 2'h2;
  localparam logic [1:0] LS_PEND_ACT = 2'h3;
  // identifier returned for group1 when acknowledge control is clear
  localparam logic [23:0] SPURIOUS_GRP1_ID = 24'h0003fe;
  localparam logic [2:0]  BP_SATURATE     = 3'h7;
endpackage

// ---- design/vmsvc_core.sv ----
// maintenance status flags and virtual machine control register
// assumes inputs synchronous to core_clk; list entry states and hypervisor
// control arrive as plain ports from the surrounding cpu interface
`timescale 1ns/1ps

module vmsvc_core #(
  parameter int          NUM_LR   = 4,     // implemented list entries
  parameter int          CNT_W    = 5,     // completion counter width
  parameter int          EISR_W   = 4,     // completion status width
  parameter logic [2:0]  PRE_BITS = 3'h4   // preemption_width field, bits minus one
) (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  // system register access
  input  wire logic                 sr_wr,
  input  wire logic                 sr_rd,
  input  wire logic [1:0]           sr_sel,
  input  wire logic                 sr_secure,
  input  wire logic [63:0]          sr_wdata,
  output logic      [63:0]          sr_rdata,
  // guest binary point access, group1 view
  input  wire logic                 guest_bp1_wr,
  input  wire logic [2:0]           guest_bp1_wdata,
  output logic      [2:0]           guest_bp1_rdata,
  // hypervisor control enables
  input  wire logic                 grp1_disabled_irq_enable,
  input  wire logic                 grp1_enabled_irq_enable,
  input  wire logic                 grp0_disabled_irq_enable,
  input  wire logic                 grp0_enabled_irq_enable,
  input  wire logic                 nothing_pending_irq_enable,
  input  wire logic                 entry_absent_irq_enable,
  input  wire logic                 few_valid_irq_enable,
  input  wire logic [CNT_W-1:0]     completion_counter,
  input  wire logic [EISR_W-1:0]    completion_status,
  // list entry states, two bits each
  input  wire logic [2*NUM_LR-1:0]  list_entry_state,
  // top pending candidate
  input  wire logic                 cand_valid,
  input  wire logic [7:0]           cand_prio,
  input  wire logic                 cand_grp1,
  input  wire logic [23:0]          cand_id,
  // completion write from the guest
  input  wire logic                 completion_wr,
  input  wire logic                 deactivate_wr,
  // outputs towards the core and list logic
  output logic                      maint_irq,
  output logic                      virq,
  output logic                      vfiq,
  output logic      [23:0]          ack_id,
  output logic                      prio_drop,
  output logic                      deact
);

  // vm control state
  logic [7:0] pmask_ff,  nxt_pmask;    // virtual_priority_mask
  logic [2:0] bp0_ff,    nxt_bp0;      // grp0_binary_point
  logic [2:0] bp1_ff,    nxt_bp1;      // grp1_binary_point
  logic       split_ff,  nxt_split;    // split_completion_mode
  logic       cbp_ff,    nxt_cbp;      // common_binary_point
  logic       fiq_ff,    nxt_fiq;      // fast_irq_routing
  logic       ack_ff,    nxt_ack;      // acknowledge_control
  logic       en1_ff,    nxt_en1;      // virtual_grp1_enable
  logic       en0_ff,    nxt_en0;      // virtual_grp0_enable
  // maintenance flags
  logic [7:0] ms_ff, nxt_ms;
  // per-entry decode
  logic [NUM_LR-1:0] lr_pend;
  logic [NUM_LR-1:0] lr_valid;
  logic [$clog2(NUM_LR+1)-1:0] valid_cnt;
  // derived minimums, group1 view, register image and signalling terms
  logic [2:0] bp0_min;
  logic [2:0] bp1_min;
  logic [2:0] bp1_view;
  logic [63:0] vmcr_word;
  logic       sig_ok;
  logic [23:0] nxt_ack_id;
  logic        nxt_virq, nxt_vfiq;

  // per-entry state decode; only list contents count, never set packets
  for (genvar g = 0; g < NUM_LR; g++) begin : g_lr
    assign lr_pend[g]  = (list_entry_state[2*g +: 2] == vmsvc_pkg::LS_PENDING) ||
                         (list_entry_state[2*g +: 2] == vmsvc_pkg::LS_PEND_ACT);
    assign lr_valid[g] = (list_entry_state[2*g +: 2] != vmsvc_pkg::LS_INVALID);
  end

  // count valid entries
  always_comb begin
    valid_cnt = '0;
    for (int i = 0; i < NUM_LR; i++) begin
      valid_cnt = valid_cnt + {{($bits(valid_cnt)-1){1'b0}}, lr_valid[i]};
    end
  end

  // binary point minimums; preemption_width field n (bits minus one) gives minimum 7-n
  assign bp0_min = 3'h7 - PRE_BITS;
  assign bp1_min = (bp0_min == vmsvc_pkg::BP_SATURATE) ? bp0_min :
                   (sr_secure ? bp0_min : bp0_min + 3'h1);
  // group1 view under common binary point
  assign bp1_view = cbp_ff ? ((bp0_ff == vmsvc_pkg::BP_SATURATE) ? vmsvc_pkg::BP_SATURATE
                                                                  : bp0_ff + 3'h1)
                           : bp1_ff;
  assign guest_bp1_rdata = bp1_view;

  // register image; reserved bits read as zero
  always_comb begin
    vmcr_word = 64'h0;
    vmcr_word[vmsvc_pkg::VC_PMASK_LSB +: 8] = pmask_ff;
    vmcr_word[vmsvc_pkg::VC_BP0_LSB +: 3]   = bp0_ff;
    vmcr_word[vmsvc_pkg::VC_BP1_LSB +: 3]   = bp1_ff;
    vmcr_word[vmsvc_pkg::VC_SPLIT]          = split_ff;
    vmcr_word[vmsvc_pkg::VC_CBP]            = cbp_ff;
    vmcr_word[vmsvc_pkg::VC_FIQ]            = fiq_ff;
    vmcr_word[vmsvc_pkg::VC_ACK]            = ack_ff;
    vmcr_word[vmsvc_pkg::VC_EN1]            = en1_ff;
    vmcr_word[vmsvc_pkg::VC_EN0]            = en0_ff;
  end

  // read data: combinational, zero when not reading
  always_comb begin
    sr_rdata = 64'h0;
    if (sr_rd) begin
      case (sr_sel)
        vmsvc_pkg::REG_MAINT_STATUS: sr_rdata = {56'h0, ms_ff};
        vmsvc_pkg::REG_VM_CONTROL:   sr_rdata = vmcr_word;
        default:                     sr_rdata = 64'h0;
      endcase
    end
  end

  // next values of the vm control register
  always_comb begin
    logic [2:0] wbp0;
    logic [2:0] wbp1;
    wbp0 = sr_wdata[vmsvc_pkg::VC_BP0_LSB +: 3];
    wbp1 = sr_wdata[vmsvc_pkg::VC_BP1_LSB +: 3];
    nxt_pmask = pmask_ff;
    nxt_bp0   = bp0_ff;
    nxt_bp1   = bp1_ff;
    nxt_split = split_ff;
    nxt_cbp   = cbp_ff;
    nxt_fiq   = fiq_ff;
    nxt_ack   = ack_ff;
    nxt_en1   = en1_ff;
    nxt_en0   = en0_ff;
    // writes to the status register fall through untouched
    if (sr_wr && (sr_sel == vmsvc_pkg::REG_VM_CONTROL)) begin
      nxt_pmask = sr_wdata[vmsvc_pkg::VC_PMASK_LSB +: 8];
      nxt_bp0   = (wbp0 < bp0_min) ? bp0_min : wbp0;
      // hypervisor write reaches group1 point whatever the common bit
      nxt_bp1   = (wbp1 < bp1_min) ? bp1_min : wbp1;
      nxt_split = sr_wdata[vmsvc_pkg::VC_SPLIT];
      nxt_cbp   = sr_wdata[vmsvc_pkg::VC_CBP];
      nxt_fiq   = sr_wdata[vmsvc_pkg::VC_FIQ];
      nxt_ack   = sr_wdata[vmsvc_pkg::VC_ACK];
      nxt_en1   = sr_wdata[vmsvc_pkg::VC_EN1];
      nxt_en0   = sr_wdata[vmsvc_pkg::VC_EN0];
    end else if (guest_bp1_wr && !cbp_ff) begin
      // guest view write; ignored under common binary point
      nxt_bp1 = (guest_bp1_wdata < bp1_min) ? bp1_min : guest_bp1_wdata;
    end
  end

  // maintenance flags, recomputed every cycle
  always_comb begin
    nxt_ms = 8'h00;
    nxt_ms[vmsvc_pkg::MS_GRP1_DIS]  = grp1_disabled_irq_enable & ~en1_ff;
    nxt_ms[vmsvc_pkg::MS_GRP1_EN]   = grp1_enabled_irq_enable  &  en1_ff;
    nxt_ms[vmsvc_pkg::MS_GRP0_DIS]  = grp0_disabled_irq_enable & ~en0_ff;
    nxt_ms[vmsvc_pkg::MS_GRP0_EN]   = grp0_enabled_irq_enable  &  en0_ff;
    nxt_ms[vmsvc_pkg::MS_NO_PEND]   = nothing_pending_irq_enable & ~(|lr_pend);
    nxt_ms[vmsvc_pkg::MS_ABSENT]    = entry_absent_irq_enable &
                                      (completion_counter != '0);
    nxt_ms[vmsvc_pkg::MS_FEW_VALID] = few_valid_irq_enable &
                                      (valid_cnt <= 1);
    nxt_ms[vmsvc_pkg::MS_COMPLETE]  = |completion_status;
  end

  // signalling of the top candidate: mask, group enables, routing
  always_comb begin
    sig_ok     = cand_valid && (cand_prio < pmask_ff);
    nxt_virq   = 1'b0;
    nxt_vfiq   = 1'b0;
    nxt_ack_id = cand_id;
    if (sig_ok && cand_grp1 && en1_ff) begin
      nxt_virq = 1'b1;
    end else if (sig_ok && !cand_grp1 && en0_ff) begin
      if (fiq_ff) begin
        nxt_vfiq = 1'b1;
      end else begin
        nxt_virq = 1'b1;
      end
    end
    if (cand_grp1 && !ack_ff) begin
      nxt_ack_id = vmsvc_pkg::SPURIOUS_GRP1_ID;
    end
  end

  // completion handling: combinational strobes
  assign prio_drop = completion_wr;
  assign deact     = split_ff ? deactivate_wr : completion_wr;
  assign maint_irq = |ms_ff;

  // register all state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pmask_ff <= vmsvc_pkg::VC_PMASK_RST;
      bp0_ff   <= 3'h0;
      bp1_ff   <= 3'h0;
      split_ff <= vmsvc_pkg::VC_BIT_RST;
      cbp_ff   <= vmsvc_pkg::VC_BIT_RST;
      fiq_ff   <= vmsvc_pkg::VC_BIT_RST;
      ack_ff   <= vmsvc_pkg::VC_BIT_RST;
      en1_ff   <= vmsvc_pkg::VC_BIT_RST;
      en0_ff   <= vmsvc_pkg::VC_BIT_RST;
      ms_ff    <= vmsvc_pkg::MS_RESET;
      virq     <= 1'b0;
      vfiq     <= 1'b0;
      ack_id   <= 24'h0;
    end else begin
      pmask_ff <= nxt_pmask;
      bp0_ff   <= nxt_bp0;
      bp1_ff   <= nxt_bp1;
      split_ff <= nxt_split;
      cbp_ff   <= nxt_cbp;
      fiq_ff   <= nxt_fiq;
      ack_ff   <= nxt_ack;
      en1_ff   <= nxt_en1;
      en0_ff   <= nxt_en0;
      ms_ff    <= nxt_ms;
      virq     <= nxt_virq;
      vfiq     <= nxt_vfiq;
      ack_id   <= nxt_ack_id;
    end
  end

  // checks; flags are registered, so each flag is held against the inputs
  // of the cycle before rather than against the same cycle
  a_grp1_dis_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    1 |=> ms_ff[7] == $past(grp1_disabled_irq_enable & ~en1_ff))
    else $error("grp1 disabled flag wrong");
  a_grp1_en_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    1 |=> ms_ff[6] == $past(grp1_enabled_irq_enable & en1_ff))
    else $error("grp1 enabled flag wrong");
  a_grp0_dis_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    1 |=> ms_ff[5] == $past(grp0_disabled_irq_enable & ~en0_ff))
    else $error("grp0 disabled flag wrong");
  a_grp0_en_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    1 |=> ms_ff[4] == $past(grp0_enabled_irq_enable & en0_ff))
    else $error("grp0 enabled flag wrong");
  a_no_pend_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    (nothing_pending_irq_enable && lr_pend == '0) |=> ms_ff[3])
    else $error("nothing pending flag missed");
  a_absent_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    (entry_absent_irq_enable && completion_counter != '0) |=> ms_ff[2])
    else $error("entry absent flag missed");
  a_few_valid_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    (few_valid_irq_enable && valid_cnt > 1) |=> !ms_ff[1])
    else $error("few valid flag set with many entries");
  a_complete_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    (completion_status != '0) |=> ms_ff[0])
    else $error("completion flag missed");
  a_status_upper: assert property (@(posedge core_clk) disable iff (!rst_n)
    (sr_rd && sr_sel == vmsvc_pkg::REG_MAINT_STATUS) |-> sr_rdata[63:8] == 56'h0)
    else $error("status upper bits not zero");
  a_irq_or: assert property (@(posedge core_clk) disable iff (!rst_n)
    maint_irq == (ms_ff != 8'h00))
    else $error("maintenance interrupt not or of flags");
  a_mask_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cand_valid && cand_prio >= pmask_ff) |=> !virq && !vfiq)
    else $error("interrupt signalled past mask");
  // reset leaves both points at zero, under the minimum; only writes clamp,
  // so these look one cycle after a write rather than at every edge
  a_bp0_clamp: assert property (@(posedge core_clk) disable iff (!rst_n)
    (sr_wr && sr_sel == vmsvc_pkg::REG_VM_CONTROL) |=> bp0_ff >= bp0_min)
    else $error("grp0 binary point below minimum");
  a_bp1_clamp: assert property (@(posedge core_clk) disable iff (!rst_n)
    (sr_wr && sr_sel == vmsvc_pkg::REG_VM_CONTROL && !sr_secure)
    |=> (bp1_ff == 3'h7 || bp1_ff > bp0_min))
    else $error("non-secure grp1 binary point below minimum");
  a_cbp_ignore: assert property (@(posedge core_clk) disable iff (!rst_n)
    (guest_bp1_wr && cbp_ff && !sr_wr) |=> $stable(bp1_ff))
    else $error("grp1 point changed under common mode");
  a_cbp_view: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cbp_ff && bp0_ff != 3'h7) |-> guest_bp1_rdata - bp0_ff == 3'h1)
    else $error("common point view not grp0 plus one");
  a_fiq_route: assert property (@(posedge core_clk) disable iff (!rst_n)
    (sig_ok && !cand_grp1 && en0_ff && fiq_ff) |=> vfiq && !virq)
    else $error("group0 not routed to fast irq");
  a_ack_hide: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cand_grp1 && !ack_ff) |=> ack_id == 24'h0003fe)
    else $error("group1 identifier not hidden");
  a_split_mode: assert property (@(posedge core_clk) disable iff (!rst_n)
    (split_ff && completion_wr && !deactivate_wr) |-> !deact)
    else $error("split mode deactivated on completion");
  a_split_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!split_ff && completion_wr) |-> deact)
    else $error("completion without split mode did not deactivate");
  a_grp1_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cand_grp1 && !en1_ff) |=> !virq && !vfiq)
    else $error("disabled group1 signalled");
  a_grp1_signal: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cand_valid && cand_prio < pmask_ff && cand_grp1 && en1_ff) |=> virq && !vfiq)
    else $error("enabled group1 not signalled as irq");
  a_grp0_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!cand_grp1 && !en0_ff) |=> !virq && !vfiq)
    else $error("disabled group0 signalled");

  // main scenarios worth seeing at least once
  c_virq: cover property (@(posedge core_clk) disable iff (!rst_n) virq);
  c_vfiq: cover property (@(posedge core_clk) disable iff (!rst_n) vfiq);
  c_maint: cover property (@(posedge core_clk) disable iff (!rst_n) maint_irq);
  c_clamp: cover property (@(posedge core_clk) disable iff (!rst_n)
    sr_wr && sr_sel == vmsvc_pkg::REG_VM_CONTROL &&
    sr_wdata[vmsvc_pkg::VC_BP0_LSB +: 3] < bp0_min);
  c_common: cover property (@(posedge core_clk) disable iff (!rst_n)
    cbp_ff && guest_bp1_wr);

endmodule

// ---- verification/vmsvc_pe_model.sv ----
// processing element model: issues system register reads and writes
// assumes one core clock; requests change 1 ns after a rising edge
`timescale 1ns/1ps
module vmsvc_pe_model (
  // clock
  input  wire logic        core_clk,
  // system register access towards the block
  output logic             sr_wr,
  output logic             sr_rd,
  output logic [1:0]       sr_sel,
  output logic             sr_secure,
  output logic [63:0]      sr_wdata,
  input  wire logic [63:0] sr_rdata
);
  // idle port at time zero
  initial begin
    {sr_wr, sr_rd, sr_secure} = 3'h0;
    sr_sel = 2'h3;
    sr_wdata = 64'h0;
  end
  // one write, held across one sampling edge; released data is inverted so
  // a block that samples late sees garbage rather than a stale word
  task automatic reg_wr(input logic [1:0] sel, input logic sec, input logic [63:0] d);
    @(posedge core_clk);
    #1;
    {sr_wr, sr_sel, sr_secure, sr_wdata} = {1'b1, sel, sec, d};
    @(posedge core_clk);
    #1;
    {sr_wr, sr_sel, sr_wdata} = {1'b0, ~sel, ~d};
  endtask
  // one read; data is taken at the edge that closes the access
  task automatic reg_rd(input logic [1:0] sel, output logic [63:0] d);
    @(posedge core_clk);
    #1;
    {sr_rd, sr_sel} = {1'b1, sel};
    @(posedge core_clk);
    d = sr_rdata;
    #1;
    {sr_rd, sr_sel} = {1'b0, ~sel};
  endtask
endmodule

// ---- verification/vcpu_maint_status_vm_control_tb.sv ----
// self-checking bench for the maintenance status and vm control block
// assumes the pe model owns the register port; all other inputs driven here
`timescale 1ns/1ps
module vcpu_maint_status_vm_control_tb;
  // clock, reset and register port
  logic        core_clk, rst_n, sr_wr, sr_rd, sr_secure;
  logic [1:0]  sr_sel;
  logic [63:0] sr_wdata, sr_rdata, rd;
  // guest view of the group1 binary point
  logic        guest_bp1_wr;
  logic [2:0]  guest_bp1_wdata, guest_bp1_rdata;
  // hypervisor enables and status inputs
  logic        grp1_disabled_irq_enable, grp1_enabled_irq_enable, grp0_disabled_irq_enable;
  logic        grp0_enabled_irq_enable, nothing_pending_irq_enable, entry_absent_irq_enable;
  logic        few_valid_irq_enable, cand_valid, cand_grp1, completion_wr, deactivate_wr;
  logic [4:0]  completion_counter;
  logic [3:0]  completion_status;
  logic [7:0]  list_entry_state, cand_prio;
  logic [23:0] cand_id, ack_id;
  // outputs
  logic        maint_irq, virq, vfiq, prio_drop, deact;
  // bookkeeping
  int          failures, n_tests, i;
  logic [14:0] sg;
  // signalling cases: {fiq, ack, en1, en0, prio, grp1, exp virq, exp vfiq}
  localparam logic [14:0] SG [7] = '{{4'h3, 8'h7f, 3'h2}, {4'hb, 8'h7f, 3'h1},
    {4'h3, 8'h80, 3'h0}, {4'h3, 8'h7f, 3'h6}, {4'h7, 8'h7f, 3'h6}, {4'h1, 8'h7f, 3'h4},
    {4'ha, 8'h00, 3'h0}};
  // list cases: {entry states, exp nothing pending, absent, few valid, completion}
  localparam logic [11:0] LS [7] = '{{8'h00, 4'ha}, {8'h01, 4'h2}, {8'h0a, 4'h8},
    {8'h40, 4'h2}, {8'h13, 4'h0}, {8'hff, 4'h0}, {8'h80, 4'ha}};
  // clamp cases: {secure, write bp0, write bp1, exp bp0, exp bp1}
  localparam logic [12:0] CL [6] = '{{1'b0, 6'o00, 6'o34}, {1'b1, 6'o00, 6'o33},
    {1'b0, 6'o56, 6'o56}, {1'b1, 6'o22, 6'o33}, {1'b0, 6'o33, 6'o34}, {1'b1, 6'o77, 6'o77}};

  vmsvc_core #(.NUM_LR(4), .CNT_W(5), .EISR_W(4), .PRE_BITS(3'h4)) uut (
    .core_clk, .rst_n, .sr_wr, .sr_rd, .sr_sel, .sr_secure, .sr_wdata, .sr_rdata,
    .guest_bp1_wr, .guest_bp1_wdata, .guest_bp1_rdata, .grp1_disabled_irq_enable,
    .grp1_enabled_irq_enable, .grp0_disabled_irq_enable, .grp0_enabled_irq_enable,
    .nothing_pending_irq_enable, .entry_absent_irq_enable, .few_valid_irq_enable,
    .completion_counter, .completion_status, .list_entry_state, .cand_valid, .cand_prio,
    .cand_grp1, .cand_id, .completion_wr, .deactivate_wr, .maint_irq, .virq, .vfiq,
    .ack_id, .prio_drop, .deact);
  vmsvc_pe_model pe (.core_clk, .sr_wr, .sr_rd, .sr_sel, .sr_secure, .sr_wdata, .sr_rdata);

  // 10 mhz core clock
  initial core_clk = 1'b0;
  always #50 core_clk = ~core_clk;

  // vm control word; bits = {split, common point, fiq, ack, en1, en0}
  function automatic logic [63:0] vm(input logic [7:0] pm, input logic [2:0] b0,
                                     input logic [2:0] b1, input logic [5:0] bits);
    vm = {32'h0, pm, b0, b1, 8'h00, bits[5], 4'h0, bits[4:0]};
  endfunction
  // compare and count; case inequality so unknowns never match
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // move inputs just after the next rising edge
  task automatic step();
    @(posedge core_clk);
    #1;
  endtask
  // single exit for both the normal end and the watchdog
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    #1000000;
    failures++;
    conclude();
  end

  // main sequence
  initial begin
    {failures, n_tests, rst_n} = '0;
    {guest_bp1_wr, guest_bp1_wdata, completion_wr, deactivate_wr, cand_valid} = '0;
    {grp1_disabled_irq_enable, grp1_enabled_irq_enable, grp0_disabled_irq_enable,
     grp0_enabled_irq_enable, nothing_pending_irq_enable, entry_absent_irq_enable,
     few_valid_irq_enable} = 7'h00;
    {completion_counter, completion_status, list_entry_state} = '0;
    {cand_prio, cand_grp1, cand_id} = '0;
    repeat (6) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    // everything comes out of reset cleared
    pe.reg_rd(2'h0, rd);
    check(rd, 64'h0);
    check({maint_irq, virq, vfiq, ack_id}, 27'h0);
    pe.reg_rd(2'h1, rd);
    check(rd, 64'h0);
    $display("test reset done");
    // reserved bits read zero; group1 point stored even with common point set
    pe.reg_wr(2'h1, 1'b0, 64'hffff_ffff_ffff_ffff);
    pe.reg_rd(2'h1, rd);
    check(rd, 64'h0000_0000_fffc_021f);
    // binary point minimum clamps, secure and non-secure
    for (i = 0; i < 6; i++) begin
      pe.reg_wr(2'h1, CL[i][12], vm(8'h5a, CL[i][11:9], CL[i][8:6], 6'h00));
      pe.reg_rd(2'h1, rd);
      check(rd, vm(8'h5a, CL[i][5:3], CL[i][2:0], 6'h00));
    end
    // status writes and unmapped selects change nothing
    pe.reg_wr(2'h0, 1'b0, 64'hff);
    pe.reg_rd(2'h0, rd);
    check(rd, 64'h0);
    pe.reg_wr(2'h2, 1'b0, 64'h1234_5678);
    pe.reg_rd(2'h2, rd);
    check(rd, 64'h0);
    pe.reg_rd(2'h1, rd);
    check(rd, vm(8'h5a, 3'h7, 3'h7, 6'h00));
    $display("test registers done");
    // group enable flags for every combination of the two vm enables
    {grp1_disabled_irq_enable, grp1_enabled_irq_enable,
     grp0_disabled_irq_enable, grp0_enabled_irq_enable} = 4'hf;
    for (i = 0; i < 4; i++) begin
      pe.reg_wr(2'h1, 1'b0, vm(8'h00, 3'h3, 3'h4, {4'h0, i[1:0]}));
      pe.reg_rd(2'h0, rd);
      check(rd, {56'h0, !i[1], i[1], !i[0], i[0], 4'h0});
      check(maint_irq, 1'b1);
    end
    $display("test group flags done");
    // list derived flags over entry state mixes
    {grp1_disabled_irq_enable, grp1_enabled_irq_enable,
     grp0_disabled_irq_enable, grp0_enabled_irq_enable} = 4'h0;
    {nothing_pending_irq_enable, entry_absent_irq_enable, few_valid_irq_enable} = 3'h7;
    for (i = 0; i < 7; i++) begin
      list_entry_state = LS[i][11:4];
      pe.reg_rd(2'h0, rd);
      check(rd, {60'h0, LS[i][3:0]});
    end
    // all entries pending and valid, so only counter and status flags remain
    {completion_counter, completion_status, list_entry_state} = {5'h01, 4'h8, 8'hff};
    pe.reg_rd(2'h0, rd);
    check(rd, 64'h5);
    {completion_counter, completion_status} = {5'h00, 4'h0};
    pe.reg_rd(2'h0, rd);
    check({rd[7:0], maint_irq}, 9'h0);
    $display("test list flags done");
    // mask, routing, group enables and acknowledge identifier
    {cand_valid, cand_id} = {1'b1, 24'h000123};
    for (i = 0; i < 7; i++) begin
      sg = SG[i];
      pe.reg_wr(2'h1, 1'b0, vm(8'h80, 3'h3, 3'h4, {2'b00, sg[14:11]}));
      {cand_prio, cand_grp1} = sg[10:2];
      step();
      check(virq, sg[1]);
      check(vfiq, sg[0]);
      if (sg[1] | sg[0]) check(ack_id, (sg[2] & !sg[13]) ? 24'h0003fe : 24'h000123);
    end
    $display("test signalling done");
    // completion with and without split mode
    for (i = 0; i < 2; i++) begin
      pe.reg_wr(2'h1, 1'b0, vm(8'h00, 3'h3, 3'h4, {i[0], 5'h00}));
      {completion_wr, deactivate_wr} = 2'b10;
      #1;
      check({prio_drop, deact}, {1'b1, !i[0]});
      step();
      {completion_wr, deactivate_wr} = 2'b01;
      #1;
      check({prio_drop, deact}, {1'b0, i[0]});
      step();
      {completion_wr, deactivate_wr} = 2'b00;
    end
    $display("test completion done");
    // guest group1 point: own value, then common point view and ignored write
    pe.reg_wr(2'h1, 1'b0, vm(8'h00, 3'h5, 3'h6, 6'h00));
    check(guest_bp1_rdata, 3'h6);
    {guest_bp1_wr, guest_bp1_wdata} = 4'hf;
    step();
    guest_bp1_wr = 1'b0;
    check(guest_bp1_rdata, 3'h7);
    pe.reg_wr(2'h1, 1'b0, vm(8'h00, 3'h4, 3'h6, 6'h10));
    check(guest_bp1_rdata, 3'h5);
    {guest_bp1_wr, guest_bp1_wdata} = 4'hc;
    step();
    guest_bp1_wr = 1'b0;
    pe.reg_rd(2'h1, rd);
    check(rd, vm(8'h00, 3'h4, 3'h6, 6'h10));
    pe.reg_wr(2'h1, 1'b0, vm(8'h00, 3'h7, 3'h6, 6'h10));
    check(guest_bp1_rdata, 3'h7);
    $display("test common point done");
    // mid-run reset clears flags and registered outputs at once
    grp1_disabled_irq_enable = 1'b1;
    step();
    step();
    check(maint_irq, 1'b1);
    rst_n = 1'b0;
    #1;
    check({maint_irq, virq, vfiq, ack_id}, 27'h0);
    step();
    rst_n = 1'b1;
    pe.reg_rd(2'h1, rd);
    check(rd, 64'h0);
    check(guest_bp1_rdata, 3'h0);
    pe.reg_rd(2'h0, rd);
    check(rd, 64'h80);
    $display("test mid-run reset done");
    conclude();
  end
endmodule
